/* File: src/sbd_bus_controller.sv */
`timescale 1ns/100ps
`default_nettype none
module sbd_bus_controller (
    input wire logic clock, // 50 MHz system clock
    input wire logic reset, // Synchronous, active high
    input wire logic clkEn, // Freezes all state when low
    input wire logic [3:0] masterReq, // Access requests per master
    input wire logic [31:0] cpuAddr, // Master 0 address
    input wire logic [1:0] cpuSize, // Master 0 size
    input wire logic [1:0] cpuType, // Master 0 type
    input wire logic [31:0] dmaAddr, // Master 1 address
    input wire logic [1:0] dmaSize, // Master 1 size
    input wire logic [1:0] dmaType, // Master 1 type
    input wire logic [31:0] usbAddr, // Master 2 address
    input wire logic [1:0] usbSize, // Master 2 size
    input wire logic [1:0] usbType, // Master 2 type
    input wire logic [31:0] ethAddr, // Master 3 address
    input wire logic [1:0] ethSize, // Master 3 size
    input wire logic [1:0] ethType, // Master 3 type
    input wire logic bootSelectPin, // Boot select strap
    input wire logic remapWrite, // Remap register write strobe
    input wire logic remapToggleBit, // Remap command data bit
    input wire logic priorityWrite, // Priority register write strobe
    input wire logic [15:0] priorityData, // Priority write data
    input wire logic statusRead, // Abort status read strobe
    input wire logic ebiRefreshIrq, // External-bus refresh error
    input wire logic [3:0] otherSysIrq, // Other system peripheral lines
    output logic [3:0] grantQ, // One-hot granted master
    output logic [31:0] memAddrQ, // Address passed to target
    output logic [1:0] accSizeQ, // Size passed to target
    output logic [1:0] accTypeQ, // Type passed to target
    output logic [7:0] chipSelQ, // External chip selects
    output logic periphSelQ, // Peripheral area select
    output logic [2:0] intSelQ, // ROM, SRAM, host slot selects
    output logic abortQ, // Abort to all masters
    output logic [31:0] abortStatusQ, // Abort status register
    output logic [31:0] abortAddrQ, // Abort address register
    output logic [15:0] masterPriorityQ, // Priority register
    output logic remapQ, // Remap state
    output logic bootRomQ, // Boot memory is the ROM
    output logic sysIrqQ // System interrupt source 1
);
    // ------------------------------------------------------------
    // Arbitration and decode
    // ------------------------------------------------------------
    logic [3:0] grantD;
    logic [31:0] selAddr;
    logic [1:0] selSize;
    logic [1:0] selType;
    logic [7:0] chipSel;
    logic periphSel;
    logic [2:0] intSel;
    logic [31:0] memAddr;
    logic undefAddr;
    logic misAddr;
    logic abortEv;
    logic [1:0] bootHistQ;
    logic srcFreshQ;

    sbd_arbiter arbiter (
        .masterReq(masterReq),
        .masterPrio(masterPriorityQ),
        .grant(grantD)
    );

    // Fixed master numbering drives the address mux
    always_comb begin
        selAddr = cpuAddr;
        selSize = cpuSize;
        selType = cpuType;
        unique case (1'b1)
            grantD[1]: begin
                selAddr = dmaAddr;
                selSize = dmaSize;
                selType = dmaType;
            end
            grantD[2]: begin
                selAddr = usbAddr;
                selSize = usbSize;
                selType = usbType;
            end
            grantD[3]: begin
                selAddr = ethAddr;
                selSize = ethSize;
                selType = ethType;
            end
            default: ;
        endcase
    end

    sbd_decoder decoder (
        .addr(selAddr),
        .size(selSize),
        .accType(selType),
        .fromCpu(grantD[sbd_pkg::CpuMaster]),
        .remapOn(remapQ),
        .bootRom(bootRomQ),
        .chipSel(chipSel),
        .periphSel(periphSel),
        .intSel(intSel),
        .memAddr(memAddr),
        .undefAddr(undefAddr),
        .misAddr(misAddr)
    );

    assign abortEv = (|grantD) && (undefAddr || misAddr);

    // ------------------------------------------------------------
    // Access outputs
    // ------------------------------------------------------------
    // An aborted access drives no select, so the target never sees it
    always_ff @(posedge clock) begin
        if (clkEn) begin
            if (reset) begin
                grantQ <= 4'h0;
                memAddrQ <= 32'h0000_0000;
                accSizeQ <= 2'h0;
                accTypeQ <= 2'h0;
                chipSelQ <= 8'h00;
                periphSelQ <= 1'b0;
                intSelQ <= 3'h0;
                abortQ <= 1'b0;
            end else begin
                grantQ <= grantD;
                memAddrQ <= memAddr;
                accSizeQ <= selSize;
                accTypeQ <= selType;
                chipSelQ <= abortEv ? 8'h00 : chipSel;
                periphSelQ <= periphSel && !abortEv;
                intSelQ <= abortEv ? 3'h0 : intSel;
                abortQ <= abortEv;
            end
        end
    end

    // ------------------------------------------------------------
    // Boot select, remap and priorities
    // ------------------------------------------------------------
    // History only samples the pin during reset, so the pin is free afterwards
    always_ff @(posedge clock) begin
        if (clkEn) begin
            if (reset) begin
                bootHistQ <= {bootHistQ[0], bootSelectPin};
                bootRomQ <= 1'b0;
            end else if (bootHistQ == sbd_pkg::BootHistHigh) begin
                bootRomQ <= 1'b1;
                bootHistQ <= 2'h0;
            end
        end
    end

    always_ff @(posedge clock) begin
        if (clkEn) begin
            if (reset) begin
                remapQ <= 1'b0;
            end else if (remapWrite && remapToggleBit) begin
                remapQ <= !remapQ;
            end
        end
    end

    always_ff @(posedge clock) begin
        if (clkEn) begin
            if (reset) begin
                masterPriorityQ <= sbd_pkg::PrioReset;
            end else if (priorityWrite) begin
                masterPriorityQ <= priorityData & sbd_pkg::PrioMask;
            end
        end
    end

    // ------------------------------------------------------------
    // Abort status
    // ------------------------------------------------------------
    // A shown abort is pushed into the sticky set only if software has
    // not read it yet; a new abort wins over a simultaneous read
    always_ff @(posedge clock) begin
        if (clkEn) begin
            if (reset) begin
                abortAddrQ <= 32'h0000_0000;
                abortStatusQ <= 32'h0000_0000;
                srcFreshQ <= 1'b0;
            end else begin
                if (abortEv) begin
                    abortAddrQ <= selAddr;
                    abortStatusQ[23:0] <= 24'h00_0000;
                    abortStatusQ[sbd_pkg::StUndBit] <= undefAddr;
                    abortStatusQ[sbd_pkg::StMisBit] <= misAddr;
                    abortStatusQ[sbd_pkg::StSizeLsb +: 2] <= selSize;
                    abortStatusQ[sbd_pkg::StTypeLsb +: 2] <= selType;
                    abortStatusQ[sbd_pkg::StSrcLsb +: 4] <= grantD;
                end
                abortStatusQ[sbd_pkg::StStickyLsb +: 4] <=
                    (statusRead ? 4'h0 :
                     abortStatusQ[sbd_pkg::StStickyLsb +: 4]) |
                    ((abortEv && srcFreshQ) ?
                     abortStatusQ[sbd_pkg::StSrcLsb +: 4] : 4'h0);
                srcFreshQ <= abortEv || (srcFreshQ && !statusRead);
            end
        end
    end

    // ------------------------------------------------------------
    // Interrupt pass-through
    // ------------------------------------------------------------
    always_ff @(posedge clock) begin
        if (clkEn) begin
            if (reset) begin
                sysIrqQ <= 1'b0;
            end else begin
                sysIrqQ <= ebiRefreshIrq ||
                    (|otherSysIrq);
            end
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking @(posedge clock); endclocking
    default disable iff (reset);

    logic prioOk;
    logic tieOk;
    always_comb begin
        prioOk = 1'b1;
        tieOk = 1'b1;
        for (int i = 0; i < sbd_pkg::NumMasters; i++) begin
            for (int w = 0; w < sbd_pkg::NumMasters; w++) begin
                if (grantD[w] && masterReq[i]) begin
                    if (sbd_pkg::prio_of(masterPriorityQ, i) >
                        sbd_pkg::prio_of(masterPriorityQ, w)) prioOk = 1'b0;
                    if (i < w && sbd_pkg::prio_of(masterPriorityQ, i) ==
                        sbd_pkg::prio_of(masterPriorityQ, w)) tieOk = 1'b0;
                end
            end
        end
    end

    prio_win_a: assert property (clkEn && |masterReq |->
        prioOk && $onehot(grantD)) else $error("lower priority won");
    tie_order_a: assert property (clkEn && |masterReq |-> tieOk)
        else $error("tie not resolved by master index");
    undef_abort_a: assert property (clkEn && |masterReq &&
        selAddr[31:28] > sbd_pkg::RegionExtLast &&
        selAddr[31:28] < sbd_pkg::RegionPeriph |=>
        abortQ && abortStatusQ[sbd_pkg::StUndBit] && chipSelQ == 8'h00)
        else $error("undefined area not aborted");
    internal_hole_a: assert property (clkEn && |masterReq &&
        selAddr[31:28] == sbd_pkg::RegionInternal &&
        selAddr[27:20] > sbd_pkg::SlotHost |=> abortQ && intSelQ == 3'h0)
        else $error("internal hole not aborted");
    misalign_a: assert property (clkEn && |masterReq &&
        selType != sbd_pkg::TypeFetch && selSize == sbd_pkg::SizeWord &&
        selAddr[1:0] != 2'h0 |=> abortQ && abortStatusQ[sbd_pkg::StMisBit])
        else $error("misaligned word not aborted");
    fetch_exempt_a: assert property (clkEn && grantD[0] &&
        selType == sbd_pkg::TypeFetch && !undefAddr |=> !abortQ)
        else $error("core fetch aborted");
    abort_addr_a: assert property (clkEn && abortEv |=>
        abortAddrQ == $past(selAddr) &&
        abortStatusQ[sbd_pkg::StSrcLsb +: 4] == $past(grantD))
        else $error("abort address or source wrong");
    status_hold_a: assert property (!(clkEn && abortEv) |=>
        $stable(abortAddrQ) && $stable(abortStatusQ[23:0]))
        else $error("abort status changed without abort");
    sticky_clear_a: assert property (clkEn && statusRead &&
        !abortEv |=> abortStatusQ[27:24] == 4'h0)
        else $error("sticky not cleared");
    remap_toggle_a: assert property (clkEn && remapWrite &&
        remapToggleBit |=> remapQ != $past(remapQ))
        else $error("remap did not toggle");
    boot_rom_a: assert property (clkEn && |masterReq && !remapQ &&
        bootRomQ && selAddr[31:20] == 12'h000 && !misAddr |=>
        intSelQ[sbd_pkg::IntSelRom] && chipSelQ == 8'h00)
        else $error("slot 0 not showing ROM");
    irq_pass_a: assert property (clkEn |=>
        sysIrqQ == $past(ebiRefreshIrq || (|otherSysIrq)))
        else $error("system interrupt mismatch");

    abort_seen_c: cover property (clkEn && abortEv);
    remap_seen_c: cover property (clkEn && remapWrite && remapToggleBit);
    tie_seen_c: cover property (clkEn && masterReq == 4'hF &&
        sbd_pkg::prio_of(masterPriorityQ, 0) ==
        sbd_pkg::prio_of(masterPriorityQ, 3));
    sticky_seen_c: cover property (abortStatusQ[27:24] != 4'h0);
endmodule
`default_nettype wire

/* File: src/sbd_pkg.sv */
package sbd_pkg;
    // ------------------------------------------------------------
    // Masters and priorities
    // ------------------------------------------------------------
    localparam int NumMasters = 4;
    localparam int PrioWidth = 3;
    localparam int PrioStride = 4;
    localparam logic [15:0] PrioReset = 16'h3210;
    localparam logic [15:0] PrioMask = 16'h7777;
    localparam int CpuMaster = 0;

    // ------------------------------------------------------------
    // Address map
    // ------------------------------------------------------------
    localparam int RegionMsb = 31;
    localparam int RegionLsb = 28;
    localparam logic [3:0] RegionInternal = 4'h0;
    localparam logic [3:0] RegionExtFirst = 4'h1;
    localparam logic [3:0] RegionExtLast = 4'h8;
    localparam logic [3:0] RegionPeriph = 4'hF;
    localparam int SlotMsb = 27;
    localparam int SlotLsb = 20;
    localparam logic [7:0] SlotBoot = 8'h00;
    localparam logic [7:0] SlotRom = 8'h01;
    localparam logic [7:0] SlotSram = 8'h02;
    localparam logic [7:0] SlotHost = 8'h03;
    localparam logic [31:0] RomSize = 32'h0002_0000;
    localparam logic [31:0] SramSize = 32'h0000_4000;
    localparam logic [31:0] SlotSize = 32'h0010_0000;
    localparam logic [31:0] AreaSize = 32'h1000_0000;
    localparam int NumChipSel = 8;
    localparam int IntSelRom = 0;
    localparam int IntSelSram = 1;
    localparam int IntSelHost = 2;

    // ------------------------------------------------------------
    // Access encodings
    // ------------------------------------------------------------
    localparam logic [1:0] SizeByte = 2'h0;
    localparam logic [1:0] SizeHalf = 2'h1;
    localparam logic [1:0] SizeWord = 2'h2;
    localparam logic [1:0] TypeRead = 2'h0;
    localparam logic [1:0] TypeWrite = 2'h1;
    localparam logic [1:0] TypeFetch = 2'h2;

    // ------------------------------------------------------------
    // Abort status layout and boot capture
    // ------------------------------------------------------------
    localparam int StUndBit = 0;
    localparam int StMisBit = 1;
    localparam int StSizeLsb = 8;
    localparam int StTypeLsb = 10;
    localparam int StSrcLsb = 16;
    localparam int StStickyLsb = 24;
    localparam logic [1:0] BootHistHigh = 2'h3;

    function automatic logic [2:0] prio_of(logic [15:0] prio, int idx);
        return prio[idx*PrioStride +: PrioWidth];
    endfunction
endpackage

/* File: src/sbd_arbiter.sv */
`timescale 1ns/100ps
`default_nettype none
module sbd_arbiter (
    input wire logic [3:0] masterReq, // Requests, bit n is master n
    input wire logic [15:0] masterPrio, // Priority fields
    output logic [3:0] grant // One-hot winner, zero when idle
);
    logic [2:0] bestPrio;
    logic found;

    // Ascending scan with strict compare keeps the lower index on a tie
    always_comb begin
        grant = 4'h0;
        bestPrio = 3'h0;
        found = 1'b0;
        for (int i = 0; i < sbd_pkg::NumMasters; i++) begin
            if (masterReq[i] &&
                (!found || sbd_pkg::prio_of(masterPrio, i) > bestPrio)) begin
                grant = 4'h0;
                grant[i] = 1'b1;
                bestPrio = sbd_pkg::prio_of(masterPrio, i);
                found = 1'b1;
            end
        end
    end
endmodule
`default_nettype wire

/* File: src/sbd_decoder.sv */
`timescale 1ns/100ps
`default_nettype none
module sbd_decoder (
    input wire logic [31:0] addr, // Access address
    input wire logic [1:0] size, // Access size
    input wire logic [1:0] accType, // Read, write or fetch
    input wire logic fromCpu, // Access issued by master 0
    input wire logic remapOn, // SRAM shown in slot 0
    input wire logic bootRom, // Boot memory is the ROM
    output logic [7:0] chipSel, // External area selects
    output logic periphSel, // Peripheral area select
    output logic [2:0] intSel, // ROM, SRAM, host slot selects
    output logic [31:0] memAddr, // Address seen by target
    output logic undefAddr, // Undefined address
    output logic misAddr // Misaligned access
);
    logic [3:0] region;
    logic [7:0] slot;

    assign region = addr[sbd_pkg::RegionMsb:sbd_pkg::RegionLsb];
    assign slot = addr[sbd_pkg::SlotMsb:sbd_pkg::SlotLsb];

    always_comb begin
        misAddr = 1'b0;
        if (!(fromCpu && accType == sbd_pkg::TypeFetch)) begin
            if (size == sbd_pkg::SizeWord) misAddr = |addr[1:0];
            if (size == sbd_pkg::SizeHalf) misAddr = addr[0];
        end
    end

    always_comb begin
        chipSel = 8'h00;
        periphSel = 1'b0;
        intSel = 3'h0;
        undefAddr = 1'b0;
        memAddr = addr & (sbd_pkg::AreaSize - 32'h1);
        if (region == sbd_pkg::RegionInternal) begin
            memAddr = addr & (sbd_pkg::SlotSize - 32'h1);
            unique case (slot)
                sbd_pkg::SlotBoot: begin
                    if (remapOn) begin
                        intSel[sbd_pkg::IntSelSram] = 1'b1;
                        memAddr = addr & (sbd_pkg::SramSize - 32'h1);
                    end else if (bootRom) begin
                        intSel[sbd_pkg::IntSelRom] = 1'b1;
                        memAddr = addr & (sbd_pkg::RomSize - 32'h1);
                    end else begin
                        chipSel[0] = 1'b1;
                    end
                end
                sbd_pkg::SlotRom: begin
                    intSel[sbd_pkg::IntSelRom] = 1'b1;
                    memAddr = addr & (sbd_pkg::RomSize - 32'h1);
                end
                sbd_pkg::SlotSram: begin
                    intSel[sbd_pkg::IntSelSram] = 1'b1;
                    memAddr = addr & (sbd_pkg::SramSize - 32'h1);
                end
                sbd_pkg::SlotHost: intSel[sbd_pkg::IntSelHost] = 1'b1;
                default: undefAddr = 1'b1;
            endcase
        end else if (region == sbd_pkg::RegionPeriph) begin
            periphSel = 1'b1;
        end else if (region >= sbd_pkg::RegionExtFirst &&
                     region <= sbd_pkg::RegionExtLast) begin
            chipSel[3'(region - sbd_pkg::RegionExtFirst)] = 1'b1;
        end else begin
            undefAddr = 1'b1;
        end
    end
endmodule
`default_nettype wire

/* File: verification/sbd_master_model.sv */
`timescale 1ns/100ps
`default_nettype none
// ------------------------------------------------------------
// One bus master: holds its request until served
// ------------------------------------------------------------
module sbd_master_model #(parameter int Idx = 0) (
    input wire logic clock, // System clock
    input wire logic go, // Start one access
    input wire logic [31:0] goAddr, // Address to issue
    input wire logic [1:0] goSize, // Size to issue
    input wire logic [1:0] goType, // Type to issue
    input wire logic [3:0] grantQ, // Grants from the controller
    input wire logic abortQ, // Broadcast abort
    input wire logic [3:0] abortSrc, // Source flags of last abort
    output logic req, // Request
    output logic [31:0] addr, // Address
    output logic [1:0] size, // Size
    output logic [1:0] accType // Type
);
    logic start;
    initial begin
        req = 1'b0;
        addr = 32'h0;
        size = 2'h0;
        accType = 2'h0;
    end
    always @(posedge clock) begin
        start = go;
        #1;
        // Abort seen by all, acted on by the issuer only
        if (req && (grantQ[Idx] || (abortQ && abortSrc[Idx]))) begin
            req = 1'b0;
            addr = ~addr; // Idle lines must not keep the old value
        end else if (start) begin
            req = 1'b1; // Little-endian only, single beats
            addr = goAddr;
            size = goSize;
            accType = goType;
        end
    end
endmodule
`default_nettype wire

/* File: verification/tb_system_bus_arbiter_decoder.sv */
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, e) begin cmp_count++; if ((a) !== (e)) begin err_count++; \
    $display("MISMATCH t=%0t got=%0h exp=%0h", $time, a, e); end end
module tb_system_bus_arbiter_decoder;
    logic clock, reset, rmW, rmBit, prW, stRd, boot, ebiIrq;
    logic [3:0] othIrq, go, grantQ, srcQ;
    logic [15:0] prD, prioQ;
    logic [31:0] goA, memAddrQ, abortStatusQ, abortAddrQ, expStat, expAddr;
    logic [1:0] goS, goT, szQ, tyQ;
    logic [7:0] chipSelQ;
    logic [2:0] intSelQ;
    logic perQ, abortQ, remapQ, bootRomQ, irqQ, unread, remapExp, bootExp;
    wire logic [3:0] req;
    wire logic [31:0] mA [4];
    wire logic [1:0] mS [4], mT [4];
    int err_count, cmp_count, seed, n;
    logic [37:0] cor [10];
    assign srcQ = abortStatusQ[19:16];
    for (genvar g = 0; g < 4; g++) begin : g_m
        sbd_master_model #(.Idx(g)) u_m (.clock(clock), .go(go[g]),
            .goAddr(goA), .goSize(goS), .goType(goT), .grantQ(grantQ),
            .abortQ(abortQ), .abortSrc(srcQ), .req(req[g]), .addr(mA[g]),
            .size(mS[g]), .accType(mT[g]));
    end
    sbd_bus_controller dut (.clock(clock), .reset(reset), .clkEn(1'b1),
        .masterReq(req), .cpuAddr(mA[0]), .cpuSize(mS[0]), .cpuType(mT[0]),
        .dmaAddr(mA[1]), .dmaSize(mS[1]), .dmaType(mT[1]), .usbAddr(mA[2]),
        .usbSize(mS[2]), .usbType(mT[2]), .ethAddr(mA[3]), .ethSize(mS[3]),
        .ethType(mT[3]), .bootSelectPin(boot), .remapWrite(rmW),
        .remapToggleBit(rmBit), .priorityWrite(prW), .priorityData(prD),
        .statusRead(stRd), .ebiRefreshIrq(ebiIrq), .otherSysIrq(othIrq),
        .grantQ(grantQ), .memAddrQ(memAddrQ), .accSizeQ(szQ), .accTypeQ(tyQ),
        .chipSelQ(chipSelQ), .periphSelQ(perQ), .intSelQ(intSelQ),
        .abortQ(abortQ), .abortStatusQ(abortStatusQ), .abortAddrQ(abortAddrQ),
        .masterPriorityQ(prioQ), .remapQ(remapQ), .bootRomQ(bootRomQ),
        .sysIrqQ(irqQ));
    function automatic logic [46:0] dec(logic [31:0] a, logic [1:0] s,
                                        logic [1:0] t, int m);
        logic u, x, p;
        logic [7:0] c;
        logic [2:0] i;
        logic [31:0] o;
        x = !(m == 0 && t == sbd_pkg::TypeFetch) &&
            ((s == sbd_pkg::SizeWord && a[1:0] != 2'h0) ||
             (s == sbd_pkg::SizeHalf && a[0]));
        u = 1'b0; p = 1'b0; c = 8'h00; i = 3'h0; o = {12'h0, a[19:0]};
        case (a[31:28])
            4'h0: begin
                if (a[27:22] != 6'h0) u = 1'b1;
                else if (a[21:20] == 2'h2 || (a[21:20] == 2'h0 && remapExp))
                    begin i = 3'h2; o = {18'h0, a[13:0]}; end
                else if (a[21:20] == 2'h3) i = 3'h4;
                else if (a[21:20] == 2'h1 || bootExp)
                    begin i = 3'h1; o = {15'h0, a[16:0]}; end
                else c = 8'h01;
            end
            4'hF: begin p = 1'b1; o = {4'h0, a[27:0]}; end
            default: if (a[31:28] <= 4'h8) begin
                c = 8'h01 << (a[31:28] - 4'h1);
                o = {4'h0, a[27:0]};
            end else u = 1'b1;
        endcase
        if (u | x) begin c = 8'h00; p = 1'b0; i = 3'h0; end
        return {u | x, u, x, c, p, i, o};
    endfunction
    task automatic conclude();
        $display("Counts: %0d compares, %0d mismatches", cmp_count, err_count);
        if (err_count == 0 && cmp_count > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    task automatic waitFor(input logic [3:0] mask);
        n = 0;
        do begin @(posedge clock); #1; n++; end
        while (!((grantQ & mask) != 4'h0 || abortQ) && n < 20);
        if (n >= 20) begin err_count++; conclude(); end
    endtask
    task automatic run(int m, logic [31:0] a, logic [1:0] s, logic [1:0] t);
        logic [46:0] e;
        e = dec(a, s, t, m);
        @(posedge clock); #1 go[m] = 1'b1; goA = a; goS = s; goT = t;
        @(posedge clock); #1 go = 4'h0;
        waitFor(4'h1 << m);
        `CHK(abortQ, e[46])
        `CHK({chipSelQ, perQ, intSelQ}, e[43:32])
        if (!e[46]) `CHK({grantQ, memAddrQ, szQ, tyQ},
            {4'h1 << m, e[31:0], s, t})
        if (e[46]) begin
            expStat = {4'h0, expStat[27:24] | (unread ? expStat[19:16] : 4'h0),
                4'h0, 4'h1 << m, 4'h0, t, s, 6'h0, e[44], e[45]};
            expAddr = a;
            unread = 1'b1;
        end
        `CHK(abortStatusQ, expStat)
        `CHK(abortAddrQ, expAddr)
    endtask
    task automatic pulse(ref logic sig, input logic v);
        @(posedge clock); #1 sig = 1'b1; rmBit = v;
        @(posedge clock); #1 sig = 1'b0;
    endtask
    task automatic rst(logic pin);
        @(posedge clock); #1 reset = 1'b1; boot = pin;
        repeat (8) @(posedge clock);
        #1 reset = 1'b0;
        @(posedge clock); #1 boot = ~pin; // Pin is free after reset
        expStat = 32'h0; expAddr = 32'h0; unread = 1'b0;
        remapExp = 1'b0; bootExp = pin;
        `CHK({bootRomQ, remapQ}, {pin, 1'b0})
        `CHK(prioQ, sbd_pkg::PrioReset)
    endtask
    initial begin
        clock = 1'b0;
        forever #10 clock = ~clock;
    end
    initial begin
        {reset, rmW, rmBit, prW, stRd, boot, ebiIrq, othIrq, go} = '0;
        {prD, goA, goS, goT} = '0;
        err_count = 0; cmp_count = 0; seed = 55335;
        cor = '{{6'h08, 32'h0000_0008}, {6'h19, 32'h0012_0008},
            {6'h24, 32'h0020_4010}, {6'h30, 32'h0030_0000},
            {6'h18, 32'h0040_0000}, {6'h21, 32'h9000_0000},
            {6'h38, 32'h8FFF_FFFC}, {6'h0A, 32'h0010_0002},
            {6'h1A, 32'h1000_0002}, {6'h24, 32'h1000_0001}};
        rst(1'b1);
        foreach (cor[k])
            run(cor[k][37:36], cor[k][31:0], cor[k][35:34],
                cor[k][33:32]);
        $display("Test corners done");
        pulse(stRd, 1'b0); unread = 1'b0; expStat[27:24] = 4'h0;
        for (int k = 0; k < 3; k++) begin
            pulse(rmW, k != 0);
            remapExp ^= (k != 0);
            `CHK(remapQ, remapExp)
            run(0, 32'h0000_0010, sbd_pkg::SizeWord,
                sbd_pkg::TypeRead);
        end
        for (int k = 0; k < 40; k++) begin
            goA = $random(seed);
            if (goA[3]) goA[31:22] = 10'h0;
            run(k % 4, goA, 2'($unsigned($random(seed)) % 3),
                2'($unsigned($random(seed)) % 3));
            if (k % 10 == 9) begin
                pulse(stRd, 1'b0); unread = 1'b0; expStat[27:24] = 4'h0;
            end
        end
        $display("Test decode done");
        for (int r = 0; r < 6; r++) begin
            logic [3:0] left, w;
            prD = (r == 0) ? 16'h5555 : 16'($random(seed));
            pulse(prW, 1'b0);
            `CHK(prioQ, prD & sbd_pkg::PrioMask)
            @(posedge clock); #1 go = 4'hF; goA = 32'h1000_0000; goS = 2'h2;
            @(posedge clock); #1 go = 4'h0;
            left = 4'hF;
            for (int k = 0; k < 4; k++) begin
                w = 4'h0;
                for (int i = 0; i < 4; i++)
                    if (left[i] && (w == 4'h0 ||
                        prD[i*4+:3] > prD[$clog2(w)*4+:3]))
                        w = 4'h1 << i;
                waitFor(4'hF);
                `CHK(grantQ, w)
                left &= ~w;
            end
        end
        $display("Test arbitration done");
        for (int k = 0; k < 8; k++) begin
            ebiIrq = 1'($random(seed)); othIrq = 4'($random(seed));
            @(posedge clock); #1;
            `CHK(irqQ, ebiIrq | (|othIrq))
        end
        // Remap left on, so the second reset has something to clear
        pulse(rmW, 1'b1);
        `CHK(remapQ, 1'b1)
        rst(1'b0);
        run(0, 32'h0000_0008, sbd_pkg::SizeWord,
            sbd_pkg::TypeRead);
        $display("Test external boot done");
        conclude();
    end
endmodule
`default_nettype wire
